// file: logic/ptt_consts.svh
/*
 Constants of the periodic tick timer: register offsets, field positions,
 reset values and timing counts. Assumes inclusion by bare name.
*/
// Contract
// - Eleven-bit prescaler counts down from preload to zero on enabled clocks.
// - Prescaler reaching zero increments the 21-bit up counter.
// - Preload zero means modulus 2048, period 2049 clocks.
// - Counter read returns up counter 31:11 and prescaler 10:0 together.
// - Counting qualified by processor state and two-bit count-enable field.
// - Tap select 13:11 picks counter bit 20..2 or, for 111, underflow.
// - Tap flag, control bit 7, sets when selected bit falls.
// - Tap request only while enable bit 6 set; flag sets regardless.
// - Compare flag sets when compare value equals up counter.
// - Compare flags bits 7,6, enables bits 5,4; request needs enable.
// - Three separate interrupt channels: tap and two compares.
// - Runs in run, idle, standby; test disables interrupts; halt unclocked.
// - Timer interrupt wakes clock module from idle or low power.
// - Oscillator select bit 14 picks oscillator clock, else PLL clock.
// - PLL off in standby only with bits 13 and 14 both set.
// - Wake with PLL off relocks; system clocks held 4096 cycles.
`ifndef PTT_CONSTS_SVH
`define PTT_CONSTS_SVH
// ==========================================================================
// Register byte offsets.
`define PTT_OFS_COUNT   8'h00
`define PTT_OFS_PRELOAD 8'h04
`define PTT_OFS_TAPCTL  8'h08
`define PTT_OFS_CMPCTL  8'h0C
`define PTT_OFS_CMP1    8'h10
`define PTT_OFS_CMP2    8'h14
`define PTT_OFS_COUNT_ENABLE_FIELD   8'h18
`define PTT_OFS_GLOBAL  8'h1C
// ==========================================================================
// Field positions.
`define PTT_TAPSEL_LSB  11
`define PTT_TAP_FLAG    7
`define PTT_TAP_EN      6
`define PTT_CF1_BIT     7
`define PTT_CF2_BIT     6
`define PTT_CE1_BIT     5
`define PTT_CE2_BIT     4
`define PTT_OSC_BIT     14
`define PTT_PLLDIS_BIT  13
// ==========================================================================
// Reset values and counts.
`define PTT_PRELOAD_RST 11'h000
`define PTT_ZERO_MOD    12'h800
`define PTT_RELOCK_CYC  4096
`define PTT_SLVERR      2'h2
`define PTT_OKAY        2'h0
`endif

// file: logic/ptt_pkg.sv
/*
 Types of the periodic tick timer. Assumes nothing of its surroundings.
*/
package ptt_pkg;
   typedef enum logic [1:0] {
      PTT_PLL_ON   = 2'h0,
      PTT_PLL_OFF  = 2'h1,
      PTT_RELOCK   = 2'h3
   } ptt_pll_e;
endpackage : ptt_pkg

// file: logic/ptt_prescale.sv
/*
 Prescaler and up counter of the periodic tick timer.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ptt_consts.svh"
module ptt_prescale
   import ptt_pkg::*;
#(
   parameter int PW = 11,
   parameter int CW = 21
) (
   // Clock and reset.
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Control.
   input  wire logic          count_ok,
   input  wire logic [PW-1:0] preload_value,
   // State.
   output logic [PW-1:0]      prescaler_value,
   output logic [CW-1:0]      up_counter_value,
   output logic               underflow
);
   typedef struct packed {
      logic [PW:0]   pre;
      logic [CW-1:0] cnt;
      logic          uf;
   } ptt_ps_s;
   ptt_ps_s st_q, st_d;
   logic [PW:0] reload;

   // ========================================================================
   // Counting.
   always_comb begin
      st_d   = st_q;
      reload = (preload_value == '0) ? (PW+1)'(`PTT_ZERO_MOD) : {1'b0, preload_value};
      st_d.uf = 1'b0;
      if (count_ok) begin
         if (st_q.pre == '0) begin
            st_d.pre = reload;
            st_d.cnt = st_q.cnt + CW'(1);
            st_d.uf  = 1'b1;
         end else begin
            st_d.pre = st_q.pre - (PW+1)'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // The modulus 2048 needs a twelfth bit; the readable field shows its low 11 bits.
   assign prescaler_value  = st_q.pre[PW-1:0];
   assign up_counter_value = st_q.cnt;
   assign underflow        = st_q.uf;

   property p_step;
      @(posedge aclk) disable iff (!aresetn)
      (count_ok && st_q.pre == '0) |=> (st_q.cnt == $past(st_q.cnt) + CW'(1));
   endproperty
   a_step: assert property (p_step) else $error("up counter did not step");

   property p_down;
      @(posedge aclk) disable iff (!aresetn)
      (count_ok && st_q.pre != '0) |=> (st_q.pre == $past(st_q.pre) - (PW+1)'(1));
   endproperty
   a_down: assert property (p_down) else $error("prescaler did not count down");

   property p_hold;
      @(posedge aclk) disable iff (!aresetn)
      !count_ok |=> $stable(st_q.pre) && $stable(st_q.cnt);
   endproperty
   a_hold: assert property (p_hold) else $error("counted while disabled");
endmodule : ptt_prescale
`default_nettype wire

// file: logic/ptt_relock.sv
/*
 Standby PLL control of the periodic tick timer: PLL off in standby and
 relock hold of system clocks. Assumes one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ptt_consts.svh"
module ptt_relock
   import ptt_pkg::*;
#(
   parameter int RELOCK_CYC = `PTT_RELOCK_CYC
) (
   // Clock and reset.
   input  wire logic aclk,
   input  wire logic aresetn,
   // Control.
   input  wire logic standby_mode,
   input  wire logic oscillator_select,
   input  wire logic pll_standby_disable,
   input  wire logic ext_wake,
   // Status.
   output logic      pll_enable,
   output logic      system_clock_hold
);
   typedef struct packed {
      ptt_pll_e    st;
      logic [12:0] cnt;
   } ptt_rl_s;
   ptt_rl_s r_q, r_d;

   // ========================================================================
   // State machine.
   always_comb begin
      r_d = r_q;
      case (r_q.st)
         PTT_PLL_ON: begin
            if (standby_mode && oscillator_select && pll_standby_disable) begin
               r_d.st = PTT_PLL_OFF;
            end
         end
         PTT_PLL_OFF: begin
            if (ext_wake) begin
               r_d.st  = PTT_RELOCK;
               r_d.cnt = 13'(RELOCK_CYC - 1);
            end
         end
         PTT_RELOCK: begin
            if (r_q.cnt == '0) begin
               r_d.st = PTT_PLL_ON;
            end else begin
               r_d.cnt = r_q.cnt - 13'h1;
            end
         end
         default: r_d.st = PTT_PLL_ON;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_q <= '{st: PTT_PLL_ON, cnt: '0};
      end else begin
         r_q <= r_d;
      end
   end

   assign pll_enable  = (r_q.st == PTT_PLL_ON);
   assign system_clock_hold = (r_q.st != PTT_PLL_ON);

   property p_relock_len;
      @(posedge aclk) disable iff (!aresetn)
      (r_q.st == PTT_RELOCK && r_q.cnt == 13'h1) |=> ##1 (r_q.st == PTT_PLL_ON);
   endproperty
   a_relock_len: assert property (p_relock_len) else $error("relock ended wrong");
endmodule : ptt_relock
`default_nettype wire

// file: logic/ptt_top.sv
/*
 Periodic tick timer: AXI4-Lite register slave, tap and compare events,
 clock source choice and standby PLL control. Assumes the timer clock equals
 aclk, with source selection reported as an output to the clock unit.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ptt_consts.svh"
module ptt_top
   import ptt_pkg::*;
#(
   parameter int PW         = 11,
   parameter int CW         = 21,
   parameter int RELOCK_CYC = `PTT_RELOCK_CYC
) (
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address.
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   // Write data.
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // Write response.
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // Read address.
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   // Read data.
   input  wire logic        s_axi_rvalid_unused_n,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Processor state.
   input  wire logic        cpu_user_mode,
   input  wire logic        test_mode,
   input  wire logic        standby_mode,
   input  wire logic        ext_wake,
   // Interrupts and clock control.
   output logic             tap_irq,
   output logic             compare_one_irq,
   output logic             compare_two_irq,
   output logic             wake_request,
   output logic             timer_clock_from_osc,
   output logic             pll_enable,
   output logic             system_clock_hold
);
   typedef struct packed {
      logic          aw_got;
      logic [7:0]    aw;
      logic          w_got;
      logic [31:0]   w;
      logic [3:0]    ws;
      logic          bv;
      logic [1:0]    br;
      logic          rv;
      logic [31:0]   rd;
      logic [1:0]    rr;
      logic [PW+2:0] pctl;
      logic          tflag;
      logic          ten;
      logic [3:0]    cint;
      logic [CW-1:0] cmp1;
      logic [CW-1:0] cmp2;
      logic [1:0]    count_enable_field;
      logic          osc;
      logic          plldis;
      logic          tbit;
      logic          irq_t;
      logic          irq_1;
      logic          irq_2;
      logic          wake;
      logic          pll_en;
      logic          hold;
   } ptt_top_s;
   ptt_top_s s_q, s_d;

   logic [PW-1:0] prescaler_value;
   logic [CW-1:0] up_counter_value;
   logic          underflow;
   logic          count_ok;
   logic          pll_en_w;
   logic          hold_w;
   logic          tap_now;
   logic          tap_fall;
   logic          m1;
   logic          m2;
   logic          do_wr;
   logic [31:0]   wmask;
   logic [2:0]    tap_select;

   // ========================================================================
   // Counting qualification.
   // Field 00 counts always; 01 counts in user mode only; 10 in privileged
   // mode only; 11 stops counting, a use for benchmarking code sections.
   always_comb begin
      case (s_q.count_enable_field)
         2'h0:    count_ok = 1'b1;
         2'h1:    count_ok = cpu_user_mode;
         2'h2:    count_ok = !cpu_user_mode;
         default: count_ok = 1'b0;
      endcase
   end

   ptt_prescale #(
      .PW (PW),
      .CW (CW)
   ) u_prescale (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .count_ok         (count_ok),
      .preload_value    (s_q.pctl[PW-1:0]),
      .prescaler_value  (prescaler_value),
      .up_counter_value (up_counter_value),
      .underflow        (underflow)
   );

   ptt_relock #(
      .RELOCK_CYC (RELOCK_CYC)
   ) u_relock (
      .aclk                (aclk),
      .aresetn             (aresetn),
      .standby_mode        (standby_mode),
      .oscillator_select   (s_q.osc),
      .pll_standby_disable (s_q.plldis),
      .ext_wake            (ext_wake),
      .pll_enable          (pll_en_w),
      .system_clock_hold         (hold_w)
   );

   // ========================================================================
   // Events.
   assign tap_select = s_q.pctl[PW+2:PW];
   always_comb begin
      case (tap_select)
         3'h0:    tap_now = up_counter_value[20];
         3'h1:    tap_now = up_counter_value[17];
         3'h2:    tap_now = up_counter_value[14];
         3'h3:    tap_now = up_counter_value[11];
         3'h4:    tap_now = up_counter_value[8];
         3'h5:    tap_now = up_counter_value[5];
         3'h6:    tap_now = up_counter_value[2];
         default: tap_now = 1'b0;
      endcase
   end
   // Underflow is a one-cycle pulse, so code 111 takes the pulse itself as the fall.
   assign tap_fall = (tap_select == 3'h7) ? underflow : (s_q.tbit && !tap_now);
   assign m1 = (s_q.cmp1 == up_counter_value);
   assign m2 = (s_q.cmp2 == up_counter_value);
   assign do_wr = s_q.aw_got && s_q.w_got && !s_q.bv;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{s_q.ws[i]}};
      end
   end

   // ========================================================================
   // Bus and register state.
   always_comb begin
      s_d = s_q;
      s_d.tbit = tap_now;
      if (s_axi_awvalid && !s_q.aw_got) begin
         s_d.aw_got = 1'b1;
         s_d.aw     = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_got) begin
         s_d.w_got = 1'b1;
         s_d.w     = s_axi_wdata;
         s_d.ws    = s_axi_wstrb;
      end
      if (s_q.bv && s_axi_bready) begin
         s_d.bv = 1'b0;
      end
      if (do_wr) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bv     = 1'b1;
         s_d.br     = `PTT_OKAY;
         case (s_q.aw)
            `PTT_OFS_COUNT: ;
            `PTT_OFS_PRELOAD: s_d.pctl = (PW+3)'((s_q.pctl & ~wmask) | (s_q.w & wmask));
            `PTT_OFS_TAPCTL: begin
               // Writing zero to the flag clears it; writing one leaves it.
               if (s_q.ws[0] && !s_q.w[`PTT_TAP_FLAG]) s_d.tflag = 1'b0;
               if (s_q.ws[0]) s_d.ten = s_q.w[`PTT_TAP_EN];
            end
            `PTT_OFS_CMPCTL: begin
               if (s_q.ws[0]) begin
                  s_d.cint[3] = s_q.cint[3] & s_q.w[`PTT_CF1_BIT];
                  s_d.cint[2] = s_q.cint[2] & s_q.w[`PTT_CF2_BIT];
                  s_d.cint[1] = s_q.w[`PTT_CE1_BIT];
                  s_d.cint[0] = s_q.w[`PTT_CE2_BIT];
               end
            end
            `PTT_OFS_CMP1: s_d.cmp1 = CW'((s_q.cmp1 & ~wmask) | (s_q.w & wmask));
            `PTT_OFS_CMP2: s_d.cmp2 = CW'((s_q.cmp2 & ~wmask) | (s_q.w & wmask));
            `PTT_OFS_COUNT_ENABLE_FIELD: if (s_q.ws[0]) s_d.count_enable_field = s_q.w[1:0];
            `PTT_OFS_GLOBAL: if (s_q.ws[1]) begin
               s_d.osc    = s_q.w[`PTT_OSC_BIT];
               s_d.plldis = s_q.w[`PTT_PLLDIS_BIT];
            end
            default: s_d.br = `PTT_SLVERR;
         endcase
      end
      // Sets come after clears so an event in the clearing cycle survives.
      if (tap_fall) s_d.tflag = 1'b1;
      if (m1) s_d.cint[3] = 1'b1;
      if (m2) s_d.cint[2] = 1'b1;
      if (s_q.rv && s_axi_rready) begin
         s_d.rv = 1'b0;
      end
      if (s_axi_arvalid && !s_q.rv) begin
         s_d.rv = 1'b1;
         s_d.rr = `PTT_OKAY;
         case (s_axi_araddr)
            `PTT_OFS_COUNT:   s_d.rd = {up_counter_value, prescaler_value};
            `PTT_OFS_PRELOAD: s_d.rd = 32'(s_q.pctl);
            `PTT_OFS_TAPCTL:  s_d.rd = 32'({s_q.tflag, s_q.ten, 6'h00});
            `PTT_OFS_CMPCTL:  s_d.rd = 32'({s_q.cint, 4'h0});
            `PTT_OFS_CMP1:    s_d.rd = 32'(s_q.cmp1);
            `PTT_OFS_CMP2:    s_d.rd = 32'(s_q.cmp2);
            `PTT_OFS_COUNT_ENABLE_FIELD:   s_d.rd = 32'(s_q.count_enable_field);
            `PTT_OFS_GLOBAL:  s_d.rd = 32'({s_q.osc, s_q.plldis, 13'h0000});
            default: begin
               s_d.rd = 32'h0000_0000;
               s_d.rr = `PTT_SLVERR;
            end
         endcase
      end
      // Three separate lines; test mode silences them all.
      s_d.irq_t  = s_q.tflag && s_q.ten && !test_mode;
      s_d.irq_1  = s_q.cint[3] && s_q.cint[1] && !test_mode;
      s_d.irq_2  = s_q.cint[2] && s_q.cint[0] && !test_mode;
      s_d.wake   = s_d.irq_t || s_d.irq_1 || s_d.irq_2;
      s_d.pll_en = pll_en_w;
      s_d.hold   = hold_w;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ========================================================================
   // Outputs.
   assign s_axi_awready        = !s_q.aw_got;
   assign s_axi_wready         = !s_q.w_got;
   assign s_axi_bvalid         = s_q.bv;
   assign s_axi_bresp          = s_q.br;
   assign s_axi_arready        = !s_q.rv;
   assign s_axi_rvalid         = s_q.rv;
   assign s_axi_rdata          = s_q.rd;
   assign s_axi_rresp          = s_q.rr;
   assign tap_irq              = s_q.irq_t;
   assign compare_one_irq      = s_q.irq_1;
   assign compare_two_irq      = s_q.irq_2;
   assign wake_request         = s_q.wake;
   assign timer_clock_from_osc = s_q.osc;
   assign pll_enable           = s_q.pll_en;
   assign system_clock_hold          = s_q.hold;

   // ========================================================================
   // Checks.
   property p_tap_set;
      @(posedge aclk) disable iff (!aresetn)
      tap_fall |=> s_q.tflag;
   endproperty
   a_tap_set: assert property (p_tap_set) else $error("tap flag missed");

   property p_tap_irq;
      @(posedge aclk) disable iff (!aresetn)
      (s_q.tflag && s_q.ten && !test_mode) |=> tap_irq;
   endproperty
   a_tap_irq: assert property (p_tap_irq) else $error("tap request missing");

   property p_no_irq_test;
      @(posedge aclk) disable iff (!aresetn)
      $past(test_mode) |-> !tap_irq && !compare_one_irq && !compare_two_irq;
   endproperty
   a_no_irq_test: assert property (p_no_irq_test) else $error("irq in test");

   property p_cmp_set;
      @(posedge aclk) disable iff (!aresetn)
      m1 |=> s_q.cint[3];
   endproperty
   a_cmp_set: assert property (p_cmp_set) else $error("compare flag missed");

   property p_cmp_irq;
      @(posedge aclk) disable iff (!aresetn)
      compare_two_irq |-> $past(s_q.cint[2] && s_q.cint[0]);
   endproperty
   a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq unenabled");

   property p_cmp1_irq;
      @(posedge aclk) disable iff (!aresetn)
      compare_one_irq |-> $past(s_q.cint[3] && s_q.cint[1] && !test_mode);
   endproperty
   a_cmp1_irq: assert property (p_cmp1_irq) else $error("compare one irq unenabled");

   property p_flag_stays;
      @(posedge aclk) disable iff (!aresetn)
      (s_q.tflag && !do_wr) |=> s_q.tflag;
   endproperty
   a_flag_stays: assert property (p_flag_stays) else $error("flag dropped");

   property p_cmp_stays;
      @(posedge aclk) disable iff (!aresetn)
      (s_q.cint[3] && !do_wr) |=> s_q.cint[3];
   endproperty
   a_cmp_stays: assert property (p_cmp_stays) else $error("compare flag dropped");

   property p_rd_answer;
      @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("no read answer");

   property p_osc;
      @(posedge aclk) disable iff (!aresetn)
      (do_wr && s_q.aw == `PTT_OFS_GLOBAL && s_q.ws[1]) |=>
         (timer_clock_from_osc == $past(s_q.w[`PTT_OSC_BIT]));
   endproperty
   a_osc: assert property (p_osc) else $error("clock source not taken");

   c_tap: cover property (@(posedge aclk) tap_irq);
   c_wake: cover property (@(posedge aclk) wake_request);
   c_cmp: cover property (@(posedge aclk) compare_one_irq);
   c_hold: cover property (@(posedge aclk) system_clock_hold);
endmodule : ptt_top
`default_nettype wire

// file: testbench/test_periodic_tick_timer.sv
/*
 Self-checking bench of the periodic tick timer: register tasks, count span,
 tap, compare and standby checks. Assumes ptt_top and ptt_consts.svh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ptt_consts.svh"
module test_periodic_tick_timer;
   // ======================================================================
   // Signals.
   localparam int RELOCK = 8;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        cpu_user_mode = 1'b0, test_mode = 1'b0;
   logic        standby_mode = 1'b0, ext_wake = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
   logic [31:0] s_axi_rdata, v1, v2, rv;
   logic        tap_irq, compare_one_irq, compare_two_irq, wake_request;
   logic        timer_clock_from_osc, pll_enable, system_clock_hold;
   int          cyc = 0, t_w, failures = 0, comparisons = 0, en, n;
   ptt_top #(.RELOCK_CYC(RELOCK)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid_unused_n(1'b0),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .cpu_user_mode(cpu_user_mode), .test_mode(test_mode),
      .standby_mode(standby_mode), .ext_wake(ext_wake), .tap_irq(tap_irq),
      .compare_one_irq(compare_one_irq), .compare_two_irq(compare_two_irq),
      .wake_request(wake_request), .timer_clock_from_osc(timer_clock_from_osc),
      .pll_enable(pll_enable), .system_clock_hold(system_clock_hold));
   always #5 aclk = ~aclk;
   // A hung handshake is cut short here; the ceiling is far above the run.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         failures++;
         test_done();
      end
   end
   // ======================================================================
   // Tasks.
   task automatic test_done();
      if (failures == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad = 1'b0;
      logic dd = 1'b0;
      @(posedge aclk);
      t_w = cyc;
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_bready  <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (!ad && s_axi_awready === 1'b1) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!dd && s_axi_wready === 1'b1) begin
            dd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      last_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      last_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // Stops, snapshots, counts en cycles in a mode (n plus one write), stops and snapshots again.
   task automatic span(input logic [1:0] m, input int n);
      int l2;
      wr(`PTT_OFS_COUNT_ENABLE_FIELD, 32'h3);
      rd(`PTT_OFS_COUNT, v1);
      wr(`PTT_OFS_COUNT_ENABLE_FIELD, {30'h0, m});
      l2 = t_w;
      repeat (n) @(posedge aclk);
      wr(`PTT_OFS_COUNT_ENABLE_FIELD, 32'h3);
      en = t_w - l2;
      rd(`PTT_OFS_COUNT, v2);
   endtask : span
   function automatic int tv(input logic [31:0] v, input int m);
      return (m + 1) * int'(v[31:11]) + (m - int'(v[10:0]));
   endfunction : tv
   // ======================================================================
   // Sequence.
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h20, rv);
      chk({30'h0, last_resp}, 32'h2);
      chk(rv, 32'h0);
      wr(`PTT_OFS_PRELOAD, 32'h5);
      rd(`PTT_OFS_PRELOAD, rv);
      chk({18'h0, rv[13:0]}, 32'h5);
      span(2'h0, 2100);
      span(2'h0, 57);
      chk(32'(tv(v2, 5) - tv(v1, 5)), 32'(en));
      for (int m = 0; m < 4; m++) begin
         for (int u = 0; u < 2; u++) begin
            cpu_user_mode <= u[0];
            span(m[1:0], 20);
            chk(32'(v1 !== v2), 32'(m == 0 || (m == 1 && u == 1) || (m == 2 && u == 0)));
         end
      end
      wr(`PTT_OFS_PRELOAD, 32'h0);
      span(2'h0, 2100);
      span(2'h0, 2049 * 4 - 9);
      chk(32'(tv(v2, 2048) - tv(v1, 2048)), 32'(en));
      for (int k = 0; k < 4; k++) begin
         n = (k == 3) ? 31 : 2 + 3 * k;
         wr(`PTT_OFS_PRELOAD, {18'h0, 3'((k == 3) ? 7 : 6 - k), 11'h2});
         span(2'h0, 2100);
         wr(`PTT_OFS_TAPCTL, 32'h0);
         span(2'h0, 3 << (n % 31 + 1));
         rd(`PTT_OFS_TAPCTL, rv);
         chk(32'(rv[7]), 32'((k == 3) ? (v1 != v2) :
            ((v2[31:11] >> (n + 1)) != (v1[31:11] >> (n + 1)))));
      end
      wr(`PTT_OFS_PRELOAD, 32'h3802);
      wr(`PTT_OFS_TAPCTL, 32'h0);
      wr(`PTT_OFS_TAPCTL, 32'h40);
      chk(32'(tap_irq), 32'h0);
      wr(`PTT_OFS_COUNT_ENABLE_FIELD, 32'h0);
      for (n = 0; n < 30 && tap_irq !== 1'b1; n++) @(posedge aclk);
      chk(32'(tap_irq), 32'h1);
      chk(32'(wake_request), 32'h1);
      wr(`PTT_OFS_COUNT_ENABLE_FIELD, 32'h3);
      test_mode <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(32'(tap_irq), 32'h0);
      test_mode <= 1'b0;
      wr(`PTT_OFS_TAPCTL, 32'h80);
      rd(`PTT_OFS_TAPCTL, rv);
      chk(32'(rv[7:6]), 32'h2);
      chk(32'(tap_irq), 32'h0);
      rd(`PTT_OFS_COUNT, rv);
      wr(`PTT_OFS_CMP1, {11'h0, rv[31:11] + 21'h2});
      wr(`PTT_OFS_CMP2, {11'h0, rv[31:11] + 21'h2});
      wr(`PTT_OFS_CMPCTL, 32'h0);
      wr(`PTT_OFS_CMPCTL, 32'h20);
      span(2'h0, 30);
      rd(`PTT_OFS_CMPCTL, rv);
      chk(32'(rv[7:4]), 32'hE);
      chk({30'h0, compare_one_irq, compare_two_irq}, 32'h2);
      wr(`PTT_OFS_CMPCTL, 32'h0);
      rd(`PTT_OFS_CMPCTL, rv);
      chk({rv[7:4], 2'h0, compare_one_irq, compare_two_irq}, 32'h0);
      wr(`PTT_OFS_GLOBAL, 32'h4000);
      standby_mode <= 1'b1;
      repeat (5) @(posedge aclk);
      chk({30'h0, timer_clock_from_osc, pll_enable}, 32'h3);
      wr(`PTT_OFS_GLOBAL, 32'h6000);
      repeat (5) @(posedge aclk);
      chk(32'(pll_enable), 32'h0);
      standby_mode <= 1'b0;
      ext_wake <= 1'b1;
      @(posedge aclk);
      ext_wake <= 1'b0;
      for (n = 0; n < 10 && system_clock_hold !== 1'b1; n++) @(posedge aclk);
      for (n = 0; n < 40 && system_clock_hold === 1'b1; n++) @(posedge aclk);
      // Hold already stands in standby; the wake edge and the output stage add two cycles.
      chk(32'(n), 32'(RELOCK + 2));
      repeat (3) @(posedge aclk);
      chk(32'(pll_enable), 32'h1);
      test_done();
   end
endmodule : test_periodic_tick_timer
`default_nettype wire
